/* File: hw/qr_valley_map.vh */
/*
 * Register map and timing counts of the switching-cycle timing block.
 * Assumes a 250 MHz core clock: every count is in 4 ns cycles.
 */
`ifndef QR_VALLEY_MAP_VH
`define QR_VALLEY_MAP_VH

// ************
// Register byte offsets, fields and reset values
// ************
`define REG_CTRL 8'h00
`define REG_FREQ_LIMIT_PIN_RES 8'h04
`define REG_STATUS 8'h08
`define REG_VALLEY_CNT 8'h0C
`define CTRL_EN_BIT 0
`define CTRL_RESET 32'h0000_0001
`define FREQ_LIMIT_PIN_RES_RESET 32'h0000_2710
`define ST_SEL_LSB 0
`define ST_MODE_BIT 4
`define ST_SOFT_BIT 5
`define ST_SKIP_BIT 6
`define ST_FREQ_LIMIT_PIN_OFF_BIT 7
`define ST_STATE_LSB 8

// ************
// Timing counts in cycles
// ************
`define STEADY_TOUT_CYC 1500
`define STARTUP_TOUT_CYC 25000
`define TRANS_TIMER_CYC 250000
`define SOFT_START_CYC 1000000
`define MIN_FREQ_CYC 10000
`define MAX_DEAD_CYC 9000

// Max-frequency period in cycles = ohms * FREQ_LIMIT_PIN_NUM / FREQ_LIMIT_PIN_DEN.
`define FREQ_LIMIT_PIN_NUM 2500
`define FREQ_LIMIT_PIN_DEN 261000

// Jitter triangle half-period in cycles and peak code.
`define JITTER_HALF_CYC 80000
`define JITTER_PEAK 8'hFF

`endif

/* File: hw/qr_valley_switch_timing.v */
/*
 * Switching-cycle timing of a quasi-resonant flyback controller, with an
 * AXI4-Lite register slave. Assumes comparator flags synchronous to aclk.
 */
// How it works
// - Jitter triangle code driven out on jitter_code.
// - Pin high disables max-frequency clamp.
// - Max-frequency period from programmed resistor.
// - Count valleys; select valley one to six.
// - Locked valley moves only on crossings.
// - Falling and rising flags per step.
// - Steady timeout counts as a valley.
// - Soft-start uses the long timeout.
// - Repeated timeouts count as valleys.
// - Sixth valley and low feedback enter foldback.
// - Foldback dead-time linear to maximum.
// - No dead-time outside foldback.
// - Peak reduction tracks feedback in foldback.
// - Exit foldback on exit-level flag.
// - Timer blocks the opposite transition.
// - Skip or fifth-valley level exits at once.
// - Force new cycle after 40 us.
// - Forced cycle waits for demagnetization.
// - Skip stops pulses; resume above hysteresis.
// - Demag-sense edge is a valley.
// - Current trip ends the drive pulse.
// - Soft-start held after reset.
`timescale 1ns/1ns
`default_nettype none
`include "qr_valley_map.vh"

module qr_valley_switch_timing #(
    parameter STARTUP_TOUT = `STARTUP_TOUT_CYC,
    parameter TRANS_TIMER = `TRANS_TIMER_CYC,
    parameter SOFT_START = `SOFT_START_CYC,
    parameter MIN_FREQ = `MIN_FREQ_CYC,
    parameter MAX_DEAD = `MAX_DEAD_CYC,
    parameter JITTER_HALF = `JITTER_HALF_CYC
) (
    // Clock and reset.
    input wire aclk,
    input wire aresetn,
    // AXI4-Lite write channels.
    input wire [7:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output wire s_axi_awready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output wire s_axi_wready,
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    // AXI4-Lite read channels.
    input wire [7:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output wire s_axi_arready,
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready,
    // Comparator flags.
    input wire demag_sense,
    input wire demag_done,
    input wire cs_trip,
    input wire freq_limit_pin,
    input wire [4:0] fb_below_fall,
    input wire [4:0] fb_above_rise,
    input wire foldback_entry_level,
    input wire foldback_exit_level,
    input wire fb_below_skip,
    input wire fb_above_skip_hysteresis,
    input wire [7:0] fb_fold_depth,
    // Drive and analog steering outputs.
    output reg gate_drive_out,
    output reg min_peak_mod_mode,
    output reg min_peak_step,
    output reg [7:0] peak_reduce,
    output reg [7:0] jitter_code,
    output reg soft_start
);

    // ************
    // Local constants and states
    // ************
    localparam [2:0] ST_IDLE = 3'd0, ST_ON = 3'd1, ST_DEMAG = 3'd2;
    localparam [2:0] ST_VALLEY = 3'd3, ST_DEAD = 3'd4, ST_READY = 3'd5;
    localparam [2:0] SEL_FIRST = 3'd1, SEL_LAST = 3'd6;

    // ************
    // Register bus slave
    // ************
    reg aw_held_reg, w_held_reg, skip_reg, read_ok;
    reg [7:0] aw_addr_reg;
    reg [3:0] w_strb_reg;
    reg [31:0] w_data_reg, ctrl_reg, freq_limit_pin_res_reg, read_value;
    reg [2:0] state_reg, sel_reg, vcount_reg;
    wire wr_go, enable;
    integer i;

    assign s_axi_awready = !aw_held_reg && !s_axi_bvalid;
    assign s_axi_wready = !w_held_reg && !s_axi_bvalid;
    assign s_axi_arready = !s_axi_rvalid;
    assign wr_go = aw_held_reg && w_held_reg && !s_axi_bvalid;
    assign enable = ctrl_reg[`CTRL_EN_BIT];

    // Address and data are caught separately, then the write completes.
    always @(posedge aclk) begin
        if (!aresetn) begin
            aw_held_reg <= 1'b0;
            w_held_reg <= 1'b0;
            aw_addr_reg <= 8'h00;
            w_data_reg <= 32'h0000_0000;
            w_strb_reg <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= 2'b00;
            ctrl_reg <= `CTRL_RESET;
            freq_limit_pin_res_reg <= `FREQ_LIMIT_PIN_RES_RESET;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held_reg <= 1'b1;
                aw_addr_reg <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_held_reg <= 1'b1;
                w_data_reg <= s_axi_wdata;
                w_strb_reg <= s_axi_wstrb;
            end
            if (wr_go) begin
                aw_held_reg <= 1'b0;
                w_held_reg <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= 2'b00;
                for (i = 0; i < 4; i = i + 1) begin
                    if (w_strb_reg[i]) begin
                        if (aw_addr_reg == `REG_CTRL) begin
                            ctrl_reg[i*8 +: 8] <= w_data_reg[i*8 +: 8];
                        end
                        if (aw_addr_reg == `REG_FREQ_LIMIT_PIN_RES) begin
                            freq_limit_pin_res_reg[i*8 +: 8] <= w_data_reg[i*8 +: 8];
                        end
                    end
                end
                if (aw_addr_reg != `REG_CTRL &&
                    aw_addr_reg != `REG_FREQ_LIMIT_PIN_RES) begin
                    s_axi_bresp <= 2'b11;
                end
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // Read decode; unmapped addresses answer a decode error and zero.
    always @* begin
        read_ok = 1'b1;
        read_value = 32'h0000_0000;
        case (s_axi_araddr)
            `REG_CTRL: read_value = ctrl_reg;
            `REG_FREQ_LIMIT_PIN_RES: read_value = freq_limit_pin_res_reg;
            `REG_STATUS: begin
                read_value[`ST_SEL_LSB +: 3] = sel_reg;
                read_value[`ST_MODE_BIT] = min_peak_mod_mode;
                read_value[`ST_SOFT_BIT] = soft_start;
                read_value[`ST_SKIP_BIT] = skip_reg;
                read_value[`ST_FREQ_LIMIT_PIN_OFF_BIT] = freq_limit_pin;
                read_value[`ST_STATE_LSB +: 3] = state_reg;
            end
            `REG_VALLEY_CNT: read_value[2:0] = vcount_reg;
            default: read_ok = 1'b0;
        endcase
    end

    // Read answer stands until the master takes it.
    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= 2'b00;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= read_value;
            s_axi_rresp <= read_ok ? 2'b00 : 2'b11;
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    // ************
    // Soft-start, skip and valley selection
    // ************
    reg [31:0] soft_cnt_reg, trans_cnt_reg;
    reg demag_dly_reg;
    wire valley_edge, trans_busy, fold_exit_now;
    assign valley_edge = demag_sense && !demag_dly_reg;
    assign trans_busy = (trans_cnt_reg != 32'h0);
    assign fold_exit_now = skip_reg || fb_above_rise[4];

    // Soft-start holds the long timeout after reset.
    always @(posedge aclk) begin
        if (!aresetn) begin
            soft_cnt_reg <= 32'h0;
            soft_start <= 1'b1;
        end else if (soft_cnt_reg >= SOFT_START - 1) begin
            soft_start <= 1'b0;
        end else begin
            soft_cnt_reg <= soft_cnt_reg + 32'h1;
        end
    end

    // Skip latch with hysteresis, and valley-sense edge delay.
    always @(posedge aclk) begin
        if (!aresetn) begin
            skip_reg <= 1'b0;
            demag_dly_reg <= 1'b0;
        end else begin
            demag_dly_reg <= demag_sense;
            if (fb_below_skip) begin
                skip_reg <= 1'b1;
            end else if (fb_above_skip_hysteresis) begin
                skip_reg <= 1'b0;
            end
        end
    end

    // Valley lock: one step per crossing of the current valley's flags.
    always @(posedge aclk) begin
        if (!aresetn) begin
            sel_reg <= SEL_FIRST;
        end else if (sel_reg != SEL_LAST &&
                     fb_below_fall[sel_reg - SEL_FIRST]) begin
            sel_reg <= sel_reg + 3'd1;
        end else if (sel_reg != SEL_FIRST &&
                     fb_above_rise[sel_reg - 3'd2]) begin
            sel_reg <= sel_reg - 3'd1;
        end
    end

    // Foldback mode entry and exit with transition timer.
    always @(posedge aclk) begin
        if (!aresetn) begin
            min_peak_mod_mode <= 1'b0;
            trans_cnt_reg <= 32'h0000_0000;
        end else if (!min_peak_mod_mode && !trans_busy &&
                     sel_reg == SEL_LAST && foldback_entry_level &&
                     !fold_exit_now) begin
            min_peak_mod_mode <= 1'b1;
            trans_cnt_reg <= TRANS_TIMER;
        end else if (min_peak_mod_mode &&
                     (fold_exit_now ||
                      (foldback_exit_level && !trans_busy))) begin
            min_peak_mod_mode <= 1'b0;
            trans_cnt_reg <= TRANS_TIMER;
        end else if (trans_busy) begin
            trans_cnt_reg <= trans_cnt_reg - 32'h0000_0001;
        end
    end

    // Peak-current steering follows the foldback mode.
    always @(posedge aclk) begin
        if (!aresetn) begin
            min_peak_step <= 1'b0;
            peak_reduce <= 8'h00;
        end else begin
            min_peak_step <= min_peak_mod_mode;
            peak_reduce <= min_peak_mod_mode ? fb_fold_depth : 8'h00;
        end
    end

    // ************
    // Jitter triangle
    // ************
    reg [31:0] jit_cnt_reg;
    reg jit_up_reg;
    // Triangle code steps once per half-period slice.
    always @(posedge aclk) begin
        if (!aresetn) begin
            jit_cnt_reg <= 32'h0000_0000;
            jit_up_reg <= 1'b1;
            jitter_code <= 8'h00;
        end else if (jit_cnt_reg >= JITTER_HALF / 256) begin
            jit_cnt_reg <= 32'h0000_0000;
            if (jit_up_reg) begin
                jitter_code <= jitter_code + 8'h01;
                if (jitter_code == `JITTER_PEAK - 8'h01) begin
                    jit_up_reg <= 1'b0;
                end
            end else begin
                jitter_code <= jitter_code - 8'h01;
                if (jitter_code == 8'h01) begin
                    jit_up_reg <= 1'b1;
                end
            end
        end else begin
            jit_cnt_reg <= jit_cnt_reg + 32'h0000_0001;
        end
    end

    // ************
    // Switching cycle sequencer
    // ************
    reg [31:0] cycle_cnt_reg, tout_cnt_reg, dead_cnt_reg;
    reg demag_seen_reg;
    wire [31:0] tout_limit, freq_limit_pin_cyc, dead_target;
    wire [39:0] dead_prod;
    wire [47:0] freq_limit_pin_prod;
    wire freq_limit_pin_ok, min_force, may_start, valley_event;
    assign tout_limit = soft_start ? STARTUP_TOUT : `STEADY_TOUT_CYC;
    // The quotient always fits 32 bits; the upper bits are dropped on purpose.
    assign freq_limit_pin_prod = freq_limit_pin_res_reg * `FREQ_LIMIT_PIN_NUM / `FREQ_LIMIT_PIN_DEN;
    assign freq_limit_pin_cyc = freq_limit_pin_prod[31:0];
    assign freq_limit_pin_ok = freq_limit_pin || (cycle_cnt_reg >= freq_limit_pin_cyc);
    assign dead_prod = MAX_DEAD * fb_fold_depth;
    assign dead_target = {8'h00, dead_prod[31:8]};
    assign min_force = demag_seen_reg &&
                       cycle_cnt_reg >= MIN_FREQ - 1;
    assign may_start = enable && !skip_reg;
    assign valley_event = valley_edge ||
                          tout_cnt_reg >= tout_limit - 1;

    // One pulse per cycle; the next starts at the selected valley.
    always @(posedge aclk) begin
        if (!aresetn) begin
            state_reg <= ST_IDLE;
            gate_drive_out <= 1'b0;
            cycle_cnt_reg <= 32'h0;
            tout_cnt_reg <= 32'h0;
            dead_cnt_reg <= 32'h0;
            vcount_reg <= 3'd0;
            demag_seen_reg <= 1'b0;
        end else begin
            cycle_cnt_reg <= cycle_cnt_reg + 32'h1;
            case (state_reg)
                ST_IDLE: begin
                    if (may_start) begin
                        state_reg <= ST_ON;
                        gate_drive_out <= 1'b1;
                        cycle_cnt_reg <= 32'h0000_0000;
                    end
                end
                ST_ON: begin
                    if (cs_trip) begin
                        gate_drive_out <= 1'b0;
                        state_reg <= ST_DEMAG;
                        demag_seen_reg <= 1'b0;
                    end
                end
                ST_DEMAG: begin
                    if (demag_done) begin
                        demag_seen_reg <= 1'b1;
                        tout_cnt_reg <= 32'h0000_0000;
                        vcount_reg <= 3'd0;
                        state_reg <= ST_VALLEY;
                    end
                end
                ST_VALLEY: begin
                    tout_cnt_reg <= tout_cnt_reg + 32'h0000_0001;
                    if (min_force) begin
                        state_reg <= ST_READY;
                    end else if (valley_event) begin
                        tout_cnt_reg <= 32'h0000_0000;
                        vcount_reg <= vcount_reg + 3'd1;
                        if (vcount_reg + 3'd1 >= sel_reg) begin
                            dead_cnt_reg <= 32'h0000_0000;
                            if (min_peak_mod_mode) begin
                                state_reg <= ST_DEAD;
                            end else begin
                                state_reg <= ST_READY;
                            end
                        end
                    end
                end
                ST_DEAD: begin
                    dead_cnt_reg <= dead_cnt_reg + 32'h0000_0001;
                    if (!min_peak_mod_mode || min_force ||
                        dead_cnt_reg >= dead_target) begin
                        state_reg <= ST_READY;
                    end
                end
                ST_READY: begin
                    if (may_start && (freq_limit_pin_ok || min_force)) begin
                        state_reg <= ST_ON;
                        gate_drive_out <= 1'b1;
                        cycle_cnt_reg <= 32'h0000_0000;
                    end
                end
                default: begin
                    state_reg <= ST_IDLE;
                    gate_drive_out <= 1'b0;
                end
            endcase
        end
    end

endmodule
`default_nettype wire

/* File: dv/qr_timing_checker_properties.sv */
/* Port-level checks for the switching-cycle timing block.
   Assumes it is bound into the block and sees only its ports. */
`timescale 1ns/1ns
`default_nettype none
module qr_timing_checker #(
    parameter SOFT_START = 500
) (
    // Clock and reset.
    input wire logic aclk,
    input wire logic aresetn,
    // Comparator flags.
    input wire logic cs_trip,
    input wire logic fb_below_skip,
    input wire logic [4:0] fb_above_rise,
    input wire logic foldback_entry_level,
    input wire logic [7:0] fb_fold_depth,
    // Drive and steering outputs.
    input wire logic gate_drive_out,
    input wire logic min_peak_mod_mode,
    input wire logic min_peak_step,
    input wire logic [7:0] peak_reduce,
    input wire logic soft_start
);
    logic [31:0] age_reg;
    // Counts cycles since reset release and saturates.
    always_ff @(posedge aclk) begin
        if (!aresetn)
            age_reg <= 32'h0000_0000;
        else if (age_reg != 32'hffff_ffff)
            age_reg <= age_reg + 32'h0000_0001;
    end
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // Steps of the foldback behaviour.
    sequence mode_entered;
        $rose(min_peak_mod_mode);
    endsequence
    sequence quiet_fb;
        !fb_below_skip && !fb_above_rise[4];
    endsequence
    AST_RESET_STATE: assert property (disable iff (1'b0)
        !aresetn |=> !gate_drive_out && !min_peak_mod_mode && soft_start)
        else $error("reset state wrong");
    AST_TRIP_ENDS: assert property (
        gate_drive_out && cs_trip |=> !gate_drive_out)
        else $error("pulse outlived trip");
    AST_SKIP_GATES: assert property (
        fb_below_skip ##1 fb_below_skip |=> !$rose(gate_drive_out))
        else $error("pulse started in skip");
    AST_ENTRY_LEVEL: assert property (
        mode_entered |-> $past(foldback_entry_level)
        || $past(foldback_entry_level, 2))
        else $error("mode entered without entry level");
    AST_STEP_RAISE: assert property (
        mode_entered |=> min_peak_step)
        else $error("minimum peak step missing");
    AST_REDUCE_ON: assert property (
        $past(min_peak_mod_mode) && min_peak_mod_mode
        |-> peak_reduce == $past(fb_fold_depth))
        else $error("peak reduction wrong");
    AST_REDUCE_OFF: assert property (
        !$past(min_peak_mod_mode) && !min_peak_mod_mode
        |-> peak_reduce == 8'h00)
        else $error("reduction outside mode");
    AST_FAST_EXIT: assert property (
        min_peak_mod_mode && (fb_below_skip || fb_above_rise[4])
        |-> ##[1:2] !min_peak_mod_mode)
        else $error("fast exit missing");
    AST_EXIT_HELD: assert property (
        mode_entered ##0 quiet_fb [*8] |-> min_peak_mod_mode)
        else $error("exit before timer");
    AST_ENTRY_HELD: assert property (
        $fell(min_peak_mod_mode) |=> !min_peak_mod_mode [*8])
        else $error("entry before timer");
    AST_SOFT_EARLY: assert property (
        age_reg < SOFT_START - 2 |-> soft_start)
        else $error("soft-start ended early");
    AST_SOFT_LATE: assert property (
        age_reg > SOFT_START + 4 |-> !soft_start)
        else $error("soft-start ended late");
endmodule
bind qr_valley_switch_timing qr_timing_checker #(
    .SOFT_START(SOFT_START)) qr_timing_checker_inst (.*);
`default_nettype wire

/* File: dv/qr_switch_partner.sv */
/* Model of the power switch and auxiliary-winding comparators.
   Assumes the bench sets the trip delay and the visible valleys. */
`timescale 1ns/1ns
`default_nettype none
module qr_switch_partner (
    // Clock and drive.
    input wire logic aclk,
    input wire logic gate_drive_out,
    // Behaviour controls.
    input wire logic [7:0] trip_delay,
    input wire logic [2:0] valley_count,
    // Comparator flags.
    output logic cs_trip,
    output logic demag_done,
    output logic demag_sense
);
    int unsigned t = 0;
    logic gate_q = 1'b0;
    // Times each phase from the last change of the drive.
    always @(posedge aclk) begin
        gate_q <= gate_drive_out;
        t <= (gate_drive_out != gate_q) ? 0 : t + 1;
    end
    // Ramp trips after the delay; demag ends 20 cycles after turn-off.
    assign cs_trip = gate_drive_out && gate_q && t >= trip_delay;
    assign demag_done = !gate_drive_out && !gate_q && t >= 20;
    // Ringing shows valleys every 16 cycles, then damps out.
    assign demag_sense = demag_done && t < 20 + 16 * valley_count
        && t[3:0] < 2;
endmodule
`default_nettype wire

/* File: dv/test_qr_valley_switch_timing.sv */
/* Self-checking bench for the switching-cycle timing block.
   Assumes the partner model and the bound checker are compiled. */
`timescale 1ns/1ns
`default_nettype none
`include "qr_valley_map.vh"
`define CHECK(nm, ex, got) begin comparisons++; if ((got) !== (ex)) begin \
    n_fail++; $display("[FAIL] %s expected %h seen %h", nm, ex, got); end end
module test_qr_valley_switch_timing;
    logic aclk = 1'b0, aresetn = 1'b0, s_axi_awvalid = 1'b0;
    logic s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0;
    logic s_axi_rready = 1'b0, freq_limit_pin = 1'b1, fb_below_skip = 1'b0;
    logic foldback_entry_level = 1'b0, foldback_exit_level = 1'b1;
    logic fb_above_skip_hysteresis = 1'b1;
    logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00, dep;
    logic [7:0] fb_fold_depth = 8'h00, trip_delay = 8'h08;
    logic [31:0] s_axi_wdata = 32'h0000_0000, d;
    logic [3:0] s_axi_wstrb = 4'hf;
    logic [4:0] fb_below_fall = 5'h00, fb_above_rise = 5'h00;
    logic [2:0] valley_count = 3'h1;
    logic [1:0] r;
    wire logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    wire logic s_axi_rvalid, demag_sense, demag_done, cs_trip, soft_start;
    wire logic gate_drive_out, min_peak_mod_mode, min_peak_step;
    wire logic [1:0] s_axi_bresp, s_axi_rresp;
    wire logic [31:0] s_axi_rdata;
    wire logic [7:0] peak_reduce, jitter_code;
    int n_fail = 0, comparisons = 0, n, m, k, res;
    qr_valley_switch_timing #(.STARTUP_TOUT(200), .TRANS_TIMER(300),
        .SOFT_START(500), .MAX_DEAD(256), .JITTER_HALF(512))
        qr_valley_switch_timing_inst (.*);
    qr_switch_partner qr_switch_partner_inst (.*);
    initial forever #2 aclk = ~aclk;
    // Prints the counts and the verdict, then stops.
    task automatic complete_run;
        $display("comparisons %0d n_fail %0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    // Period in cycles of the maximum-frequency clamp.
    function automatic int freq_limit_pin_cyc(int ohms);
        return ohms * 2500 / 261000;
    endfunction
    // One AXI4-Lite write; address and data offered together.
    task automatic axi_write(input logic [7:0] a, input logic [31:0] v,
            output logic [1:0] rsp);
        bit aw, w;
        @(posedge aclk);
        {aw, w} = 2'b11;
        s_axi_awaddr <= a;
        s_axi_wdata <= v;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'b111;
        for (k = 0; k < 200 && (aw || w || !s_axi_bvalid); k++) begin
            @(posedge aclk);
            if (aw && s_axi_awready) begin
                aw = 1'b0;
                s_axi_awvalid <= 1'b0;
            end
            if (w && s_axi_wready) begin
                w = 1'b0;
                s_axi_wvalid <= 1'b0;
            end
        end
        rsp = s_axi_bresp;
        s_axi_bready <= 1'b0;
        if (k == 200) begin
            n_fail++;
            complete_run();
        end
    endtask
    // One AXI4-Lite read.
    task automatic axi_read(input logic [7:0] a, output logic [31:0] v,
            output logic [1:0] rsp);
        bit ar;
        @(posedge aclk);
        ar = 1'b1;
        s_axi_araddr <= a;
        {s_axi_arvalid, s_axi_rready} <= 2'b11;
        for (k = 0; k < 200 && (ar || !s_axi_rvalid); k++) begin
            @(posedge aclk);
            if (ar && s_axi_arready) begin
                ar = 1'b0;
                s_axi_arvalid <= 1'b0;
            end
        end
        {v, rsp} = {s_axi_rdata, s_axi_rresp};
        s_axi_rready <= 1'b0;
        if (k == 200) begin
            n_fail++;
            complete_run();
        end
    endtask
    // Waits, bounded, until the drive or the mode reaches a level.
    task automatic wait_sig(input bit sel, input logic lvl, output int c);
        for (c = 0; (sel ? min_peak_mod_mode : gate_drive_out) !== lvl;
                c++) begin
            @(posedge aclk);
            if (c > 20000) begin
                n_fail++;
                complete_run();
            end
        end
    endtask
    // Counts drive pulse starts over a number of cycles.
    task automatic count_rises(input int cyc, output int c);
        logic prev;
        prev = gate_drive_out;
        c = 0;
        repeat (cyc) begin
            @(posedge aclk);
            c += (gate_drive_out && !prev) ? 1 : 0;
            prev = gate_drive_out;
        end
    endtask
    // Main sequence.
    initial begin
        void'($urandom(32'h1aac_5f09));
        trip_delay <= 8'($urandom_range(20, 4));
        repeat (6) @(posedge aclk);
        aresetn <= 1'b1;
        axi_read(`REG_STATUS, d, r);
        `CHECK("sel", 3'h1, d[2:0])
        `CHECK("mode", 1'b0, d[`ST_MODE_BIT])
        `CHECK("soft", 1'b1, d[`ST_SOFT_BIT])
        `CHECK("freq_limit_pin_off", 1'b1, d[`ST_FREQ_LIMIT_PIN_OFF_BIT])
        axi_read(`REG_CTRL, d, r);
        `CHECK("ctrl", `CTRL_RESET, d)
        axi_read(`REG_FREQ_LIMIT_PIN_RES, d, r);
        `CHECK("freq_limit_pin_res", `FREQ_LIMIT_PIN_RES_RESET, d)
        axi_read(8'h10, d, r);
        `CHECK("rresp", 2'b11, r)
        `CHECK("rdata", 32'h0000_0000, d)
        axi_write(8'h10, 32'h0000_0005, r);
        `CHECK("bresp", 2'b11, r)
        axi_write(`REG_STATUS, 32'h0000_0007, r);
        axi_read(`REG_STATUS, d, r);
        `CHECK("ro_sel", 3'h1, d[2:0])
        repeat (520) @(posedge aclk);
        axi_read(`REG_STATUS, d, r);
        `CHECK("soft_end", 1'b0, d[`ST_SOFT_BIT])
        d[7:0] = jitter_code;
        repeat (3) @(posedge aclk);
        d[15:8] = jitter_code - d[7:0];
        `CHECK("jitter", 1'b1, d[15:8] == 8'h01 || d[15:8] == 8'hff)
        // Programmed maximum frequency, measured rise to rise.
        res = $urandom_range(30000, 15000);
        axi_write(`REG_FREQ_LIMIT_PIN_RES, res, r);
        freq_limit_pin <= 1'b0;
        for (k = 0; k < 2; k++)
            wait_sig(0, k[0], n);
        wait_sig(0, 1'b0, n);
        wait_sig(0, 1'b1, m);
        `CHECK("freq_limit_pin", 1'b1, n + m >= freq_limit_pin_cyc(res))
        `CHECK("freq_limit_pin_hi", 1'b1, n + m <= freq_limit_pin_cyc(res) + 8)
        freq_limit_pin <= 1'b1;
        // Skip stops pulses and holds them off until the hysteresis.
        {fb_below_skip, fb_above_skip_hysteresis} <= 2'b10;
        repeat (40) @(posedge aclk);
        count_rises(1000, n);
        `CHECK("skip_off", 0, n)
        fb_below_skip <= 1'b0;
        count_rises(1000, n);
        `CHECK("skip_held", 0, n)
        fb_above_skip_hysteresis <= 1'b1;
        count_rises(1000, n);
        `CHECK("skip_resume", 1'b1, n > 0)
        // Falling thresholds step the valley down to the sixth.
        for (int j = 0; j < 5; j++) begin
            fb_below_fall <= 5'((2 << j) - 1);
            repeat (4) @(posedge aclk);
            axi_read(`REG_STATUS, d, r);
            `CHECK("sel_down", 3'(j + 2), d[2:0])
        end
        fb_below_fall <= 5'h00;
        repeat (20) @(posedge aclk);
        axi_read(`REG_STATUS, d, r);
        `CHECK("sel_lock", 3'h6, d[2:0])
        // Two valleys seen, sixth selected: four timeouts after the last.
        valley_count <= 3'h2;
        wait_sig(0, 1'b1, n);
        wait_sig(0, 1'b0, n);
        wait_sig(0, 1'b1, n);
        `CHECK("timeouts", 1'b1, n >= 6040 && n <= 6060)
        valley_count <= 3'h1;
        fb_above_rise <= 5'h10;
        repeat (20) @(posedge aclk);
        axi_read(`REG_STATUS, d, r);
        `CHECK("sel_up", 3'h5, d[2:0])
        // Foldback entry, timed exit and fast exit.
        {fb_below_fall, fb_above_rise} <= {5'h1f, 5'h00};
        dep = 8'($urandom_range(255, 1));
        fb_fold_depth <= dep;
        {foldback_entry_level, foldback_exit_level} <= 2'b10;
        wait_sig(1, 1'b1, n);
        repeat (3) @(posedge aclk);
        `CHECK("reduce", dep, peak_reduce)
        `CHECK("step", 1'b1, min_peak_step)
        {foldback_entry_level, foldback_exit_level} <= 2'b01;
        repeat (150) @(posedge aclk);
        `CHECK("held", 1'b1, min_peak_mod_mode)
        wait_sig(1, 1'b0, n);
        `CHECK("exit_late", 1'b1, n > 100)
        repeat (3) @(posedge aclk);
        `CHECK("reduce_off", 8'h00, peak_reduce)
        repeat (400) @(posedge aclk);
        {foldback_entry_level, foldback_exit_level} <= 2'b10;
        wait_sig(1, 1'b1, n);
        {fb_below_skip, fb_above_skip_hysteresis} <= 2'b10;
        repeat (3) @(posedge aclk);
        `CHECK("fast_exit", 1'b0, min_peak_mod_mode)
        complete_run();
    end
endmodule
`default_nettype wire
